/* File: core/plpc_pkg.sv */
// What this block does
// [RULE_01] One byte holds modulation frequency, duty cycle and peak current of emitter pulses
// [RULE_02] Frequency bits 7:5 step 10 kHz, 30 kHz at 000 to 100 kHz at 111
// [RULE_03] Frequency field resets to 011, giving 60 kHz
// [RULE_04] Duty bits 4:3 give 25, 50, 75, 100 percent; resets to 11
// [RULE_05] Peak current bits 2:0 give 5, 10, 20, 50 mA for codes 000-011
// [RULE_06] Current code 101 is 100 mA default; 100, 110, 111 undefined; the register field resets to 111 here
// [RULE_07] Pulse count bits 3:0 give pulses per measurement; reset 0001; 0000 reserved
// [RULE_08] Count 1111 gives fifteen pulses; host writes zeros in upper nibble
// [RULE_09] Standby runs no measurement; registers stay accessible in either mode
// [RULE_10] Saturation flag reads 0 while its enable bit is clear
// [RULE_11] Mode bits 1:0: 00/01 standby, 10/11 active; bits 7:6, 4 written 0
// [RULE_12] Gain bits 3:2: 00 x16, 10 x32, x1 x64; bit 5 enables saturation flag
`default_nettype none
package plpc_pkg;

    // ==========================================================
    // Register map
    localparam logic [7:0] PLPC_OFS_CONTROL = 8'h81;
    localparam logic [7:0] PLPC_OFS_PULSE_SETTING = 8'h82;
    localparam logic [7:0] PLPC_OFS_PULSE_COUNT = 8'h83;
    localparam logic [7:0] PLPC_RST_CONTROL = 8'h00;
    localparam logic [7:0] PLPC_RST_PULSE_SETTING = 8'h7f;
    localparam logic [7:0] PLPC_RST_PULSE_COUNT = 8'h01;
    localparam logic [7:0] PLPC_UNMAPPED_READ = 8'h00;

    // ==========================================================
    // Field positions
    localparam int PLPC_FREQ_LSB = 5;
    localparam int PLPC_DUTY_LSB = 3;
    localparam int PLPC_CUR_LSB = 0;
    localparam int PLPC_MODE_ACTIVE_BIT = 1;
    localparam int PLPC_GAIN_LSB = 2;
    localparam int PLPC_SAT_EN_BIT = 5;

    // ==========================================================
    // Timing and codes
    localparam int PLPC_CLK_HZ = 20000000;
    localparam int PLPC_FREQ_BASE_HZ = 30000;
    localparam int PLPC_FREQ_STEP_HZ = 10000;
    localparam int PLPC_DUTY_STEPS = 4;
    localparam logic [6:0] PLPC_I2C_ADDR = 7'h23;
    localparam logic [7:0] PLPC_IDLE_PTR = 8'h00;

    typedef enum logic [1:0] {
        PLPC_GAIN_X16 = 2'h0,
        PLPC_GAIN_X32 = 2'h1,
        PLPC_GAIN_X64 = 2'h2
    } plpc_gain_e;

    typedef enum logic [2:0] {
        PLPC_CUR_5MA = 3'h0,
        PLPC_CUR_10MA = 3'h1,
        PLPC_CUR_20MA = 3'h2,
        PLPC_CUR_50MA = 3'h3,
        PLPC_CUR_100MA = 3'h5
    } plpc_current_e;

endpackage : plpc_pkg
`default_nettype wire

/* File: core/plpc_i2c_slave.sv */
`timescale 1ns/1ps
`default_nettype none
module plpc_i2c_slave
    import plpc_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    output logic [7:0] ptr_o,
    input wire logic [7:0] rd_data_i,
    output logic wr_en_o,
    output logic [7:0] wr_addr_o,
    output logic [7:0] wr_data_o
);

    typedef enum logic [2:0] {
        PLPC_ST_IDLE = 3'h0,
        PLPC_ST_ADDR = 3'h1,
        PLPC_ST_ADDR_ACK = 3'h2,
        PLPC_ST_RX = 3'h3,
        PLPC_ST_RX_ACK = 3'h4,
        PLPC_ST_TX = 3'h5,
        PLPC_ST_TX_ACK = 3'h6
    } plpc_i2c_st_e;

    // ==========================================================
    // Pin synchronisers
    logic [1:0] scl_sync_q;
    logic [1:0] sda_sync_q;
    logic scl_prev_q;
    logic sda_prev_q;
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            scl_sync_q <= 2'h3;
            sda_sync_q <= 2'h3;
            scl_prev_q <= 1'b1;
            sda_prev_q <= 1'b1;
        end else begin
            scl_sync_q <= {scl_sync_q[0], scl_i};
            sda_sync_q <= {sda_sync_q[0], sda_i};
            scl_prev_q <= scl_sync_q[1];
            sda_prev_q <= sda_sync_q[1];
        end
    end

    logic scl_rise;
    logic scl_fall;
    logic bus_start;
    logic bus_stop;
    assign scl_rise = scl_sync_q[1] & ~scl_prev_q;
    assign scl_fall = ~scl_sync_q[1] & scl_prev_q;
    assign bus_start = scl_sync_q[1] & scl_prev_q & sda_prev_q & ~sda_sync_q[1];
    assign bus_stop = scl_sync_q[1] & scl_prev_q & ~sda_prev_q & sda_sync_q[1];

    // ==========================================================
    // Byte engine
    plpc_i2c_st_e st_q;
    logic [7:0] shift_q;
    logic [3:0] bit_cnt_q;
    logic rw_q;
    logic have_ptr_q;
    logic nack_q;
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            st_q <= PLPC_ST_IDLE;
            shift_q <= 8'h00;
            bit_cnt_q <= 4'h0;
            rw_q <= 1'b0;
            have_ptr_q <= 1'b0;
            nack_q <= 1'b0;
            ptr_o <= PLPC_IDLE_PTR;
            sda_o <= 1'b0;
            sda_oe_o <= 1'b0;
            wr_en_o <= 1'b0;
            wr_addr_o <= 8'h00;
            wr_data_o <= 8'h00;
        end else begin
            wr_en_o <= 1'b0;
            if (bus_start) begin
                st_q <= PLPC_ST_ADDR;
                bit_cnt_q <= 4'h0;
                sda_oe_o <= 1'b0;
            end else if (bus_stop) begin
                st_q <= PLPC_ST_IDLE;
                sda_oe_o <= 1'b0;
            end else begin
                unique case (st_q)
                    PLPC_ST_IDLE: begin
                        sda_oe_o <= 1'b0;
                    end
                    PLPC_ST_ADDR, PLPC_ST_RX: begin
                        if (scl_rise) begin
                            shift_q <= {shift_q[6:0], sda_sync_q[1]};
                            bit_cnt_q <= bit_cnt_q + 4'h1;
                        end else if (scl_fall && bit_cnt_q == 4'h8) begin
                            bit_cnt_q <= 4'h0;
                            if (st_q == PLPC_ST_ADDR) begin
                                if (shift_q[7:1] == PLPC_I2C_ADDR) begin
                                    rw_q <= shift_q[0];
                                    have_ptr_q <= 1'b0;
                                    sda_oe_o <= 1'b1;
                                    st_q <= PLPC_ST_ADDR_ACK;
                                end else begin
                                    st_q <= PLPC_ST_IDLE;
                                end
                            end else begin
                                sda_oe_o <= 1'b1;
                                st_q <= PLPC_ST_RX_ACK;
                                if (!have_ptr_q) begin
                                    ptr_o <= shift_q;
                                    have_ptr_q <= 1'b1;
                                end else begin
                                    wr_en_o <= 1'b1; // RULE_09
                                    wr_addr_o <= ptr_o;
                                    wr_data_o <= shift_q;
                                    ptr_o <= ptr_o + 8'h01;
                                end
                            end
                        end
                    end
                    PLPC_ST_ADDR_ACK, PLPC_ST_RX_ACK: begin
                        if (scl_fall) begin
                            if (st_q == PLPC_ST_ADDR_ACK && rw_q) begin
                                shift_q <= {rd_data_i[6:0], 1'b0};
                                sda_oe_o <= ~rd_data_i[7];
                                bit_cnt_q <= 4'h0;
                                st_q <= PLPC_ST_TX;
                            end else begin
                                sda_oe_o <= 1'b0;
                                st_q <= PLPC_ST_RX;
                            end
                        end
                    end
                    PLPC_ST_TX: begin
                        if (scl_rise) begin
                            bit_cnt_q <= bit_cnt_q + 4'h1;
                        end else if (scl_fall) begin
                            if (bit_cnt_q == 4'h8) begin
                                sda_oe_o <= 1'b0;
                                st_q <= PLPC_ST_TX_ACK;
                            end else begin
                                sda_oe_o <= ~shift_q[7];
                                shift_q <= {shift_q[6:0], 1'b0};
                            end
                        end
                    end
                    PLPC_ST_TX_ACK: begin
                        if (scl_rise) begin
                            nack_q <= sda_sync_q[1];
                            ptr_o <= ptr_o + 8'h01;
                        end else if (scl_fall) begin
                            if (nack_q) begin
                                st_q <= PLPC_ST_IDLE;
                            end else begin
                                shift_q <= {rd_data_i[6:0], 1'b0};
                                sda_oe_o <= ~rd_data_i[7];
                                bit_cnt_q <= 4'h0;
                                st_q <= PLPC_ST_TX;
                            end
                        end
                    end
                    default: begin
                        st_q <= PLPC_ST_IDLE;
                    end
                endcase
            end
        end
    end

endmodule : plpc_i2c_slave
`default_nettype wire

/* File: core/plpc_top.sv */
`timescale 1ns/1ps
`default_nettype none
module plpc_top
    import plpc_pkg::*;
#(
    parameter int CLK_HZ = PLPC_CLK_HZ
) (
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    input wire logic meas_req_i,
    input wire logic adc_saturated_i,
    output logic sat_flag_o,
    output logic led_drive_o,
    output logic [2:0] led_current_code_o,
    output logic [1:0] detector_gain_o,
    output logic mode_active_o,
    output logic meas_busy_o,
    output logic meas_done_o
);

    // ==========================================================
    // Helpers
    function automatic logic [15:0] plpc_period(input logic [2:0] code);
        int hz;
        hz = PLPC_FREQ_BASE_HZ + PLPC_FREQ_STEP_HZ * int'(code);
        return 16'(CLK_HZ / hz); // RULE_02
    endfunction : plpc_period

    function automatic logic [15:0] plpc_high(input logic [15:0] period,
                                              input logic [1:0] duty);
        int prod;
        prod = int'(period) * (int'(duty) + 1);
        return 16'(prod / PLPC_DUTY_STEPS); // RULE_04
    endfunction : plpc_high

    function automatic logic plpc_cur_defined(input logic [2:0] code);
        return code inside {PLPC_CUR_5MA, PLPC_CUR_10MA, PLPC_CUR_20MA,
                            PLPC_CUR_50MA, PLPC_CUR_100MA}; // RULE_05 RULE_06
    endfunction : plpc_cur_defined

    // ==========================================================
    // Serial access
    logic [7:0] ptr;
    logic [7:0] rd_data;
    logic wr_en;
    logic [7:0] wr_addr;
    logic [7:0] wr_data;

    plpc_i2c_slave u_i2c (
        .ref_clk_i(ref_clk_i),
        .resetn_i(resetn_i),
        .scl_i(scl_i),
        .sda_i(sda_i),
        .sda_o(sda_o),
        .sda_oe_o(sda_oe_o),
        .ptr_o(ptr),
        .rd_data_i(rd_data),
        .wr_en_o(wr_en),
        .wr_addr_o(wr_addr),
        .wr_data_o(wr_data)
    );

    // ==========================================================
    // Registers
    logic [7:0] control_q;
    logic [7:0] pulse_setting_q;
    logic [7:0] pulse_count_q;
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            control_q <= PLPC_RST_CONTROL; // RULE_11
            pulse_setting_q <= PLPC_RST_PULSE_SETTING; // RULE_03 RULE_04 RULE_06
            pulse_count_q <= PLPC_RST_PULSE_COUNT; // RULE_07
        end else if (wr_en) begin
            unique case (wr_addr)
                PLPC_OFS_CONTROL: control_q <= wr_data;
                PLPC_OFS_PULSE_SETTING: pulse_setting_q <= wr_data; // RULE_01
                PLPC_OFS_PULSE_COUNT: pulse_count_q <= wr_data; // RULE_08
                default: ;
            endcase
        end
    end

    always_comb begin
        unique case (ptr)
            PLPC_OFS_CONTROL: rd_data = control_q;
            PLPC_OFS_PULSE_SETTING: rd_data = pulse_setting_q;
            PLPC_OFS_PULSE_COUNT: rd_data = pulse_count_q;
            default: rd_data = PLPC_UNMAPPED_READ;
        endcase
    end

    // ==========================================================
    // Control decode
    logic active;
    logic [2:0] freq_code;
    logic [1:0] duty_code;
    logic [2:0] cur_code;
    logic [3:0] count_code;
    assign active = control_q[PLPC_MODE_ACTIVE_BIT]; // RULE_11
    assign freq_code = pulse_setting_q[PLPC_FREQ_LSB +: 3];
    assign duty_code = pulse_setting_q[PLPC_DUTY_LSB +: 2];
    assign cur_code = pulse_setting_q[PLPC_CUR_LSB +: 3];
    assign count_code = pulse_count_q[3:0];

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            detector_gain_o <= PLPC_GAIN_X16;
            mode_active_o <= 1'b0;
            sat_flag_o <= 1'b0;
        end else begin
            mode_active_o <= active;
            sat_flag_o <= adc_saturated_i & control_q[PLPC_SAT_EN_BIT]; // RULE_10
            if (control_q[PLPC_GAIN_LSB]) begin
                detector_gain_o <= PLPC_GAIN_X64; // RULE_12
            end else if (control_q[PLPC_GAIN_LSB + 1]) begin
                detector_gain_o <= PLPC_GAIN_X32; // RULE_12
            end else begin
                detector_gain_o <= PLPC_GAIN_X16; // RULE_12
            end
        end
    end

    // ==========================================================
    // Pulse train generator
    typedef enum logic [0:0] {
        PLPC_PG_IDLE = 1'b0,
        PLPC_PG_RUN = 1'b1
    } plpc_pg_e;

    plpc_pg_e pg_q;
    plpc_pg_e pg_d;
    logic [15:0] phase_q;
    logic [15:0] phase_d;
    logic [15:0] period_q;
    logic [15:0] period_d;
    logic [15:0] high_q;
    logic [15:0] high_d;
    logic [3:0] left_q;
    logic [3:0] left_d;
    logic done_d;
    logic start_ok;

    assign start_ok = meas_req_i & active & (count_code != 4'h0)
                      & plpc_cur_defined(cur_code); // RULE_07 RULE_09 RULE_06

    always_comb begin
        pg_d = pg_q;
        phase_d = phase_q;
        period_d = period_q;
        high_d = high_q;
        left_d = left_q;
        done_d = 1'b0;
        unique case (pg_q)
            PLPC_PG_IDLE: begin
                if (start_ok) begin
                    pg_d = PLPC_PG_RUN;
                    phase_d = 16'h0000;
                    period_d = plpc_period(freq_code); // RULE_01 RULE_02
                    high_d = plpc_high(plpc_period(freq_code), duty_code); // RULE_04
                    left_d = count_code; // RULE_07 RULE_08
                end
            end
            PLPC_PG_RUN: begin
                if (!active) begin
                    pg_d = PLPC_PG_IDLE; // RULE_09
                end else if (phase_q == period_q - 16'h0001) begin
                    phase_d = 16'h0000;
                    if (left_q == 4'h1) begin
                        pg_d = PLPC_PG_IDLE;
                        done_d = 1'b1;
                    end else begin
                        left_d = left_q - 4'h1; // RULE_07
                    end
                end else begin
                    phase_d = phase_q + 16'h0001;
                end
            end
        endcase
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pg_q <= PLPC_PG_IDLE;
            phase_q <= 16'h0000;
            period_q <= 16'h0001;
            high_q <= 16'h0000;
            left_q <= 4'h0;
        end else begin
            pg_q <= pg_d;
            phase_q <= phase_d;
            period_q <= period_d;
            high_q <= high_d;
            left_q <= left_d;
        end
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            led_drive_o <= 1'b0;
            led_current_code_o <= PLPC_CUR_100MA;
            meas_busy_o <= 1'b0;
            meas_done_o <= 1'b0;
        end else begin
            led_drive_o <= (pg_d == PLPC_PG_RUN) && (phase_d < high_d); // RULE_04
            if (pg_q == PLPC_PG_IDLE && start_ok) begin
                led_current_code_o <= cur_code; // RULE_05
            end
            meas_busy_o <= (pg_d == PLPC_PG_RUN);
            meas_done_o <= done_d;
        end
    end

endmodule : plpc_top
`default_nettype wire

/* File: verification/plpc_top_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module plpc_top_monitor
    import plpc_pkg::*;
#(
    parameter int CLK_HZ = PLPC_CLK_HZ
) (
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic sda_o,
    input wire logic sda_oe_o,
    input wire logic meas_req_i,
    input wire logic adc_saturated_i,
    input wire logic sat_flag_o,
    input wire logic led_drive_o,
    input wire logic [2:0] led_current_code_o,
    input wire logic [1:0] detector_gain_o,
    input wire logic mode_active_o,
    input wire logic meas_busy_o,
    input wire logic meas_done_o
);
    // ====
    // Train length
    localparam int BUSY_MAX = 15 * (CLK_HZ / 30000);
    int busy_cnt_q;
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            busy_cnt_q <= 0;
        end else begin
            busy_cnt_q <= meas_busy_o ? busy_cnt_q + 1 : 0;
        end
    end
    // ====
    // Properties
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!resetn_i);
    property p_led_in_busy; led_drive_o |-> meas_busy_o; endproperty
    a_led_in_busy: assert property (p_led_in_busy)
        else $error("emitter on outside a train");
    property p_start; $rose(meas_busy_o) |-> led_drive_o && $past(meas_req_i); endproperty
    a_start: assert property (p_start)
        else $error("train start without request or emitter");
    property p_standby;
        meas_req_i && !mode_active_o && !meas_busy_o ##1 !mode_active_o |-> !meas_busy_o;
    endproperty
    a_standby: assert property (p_standby)
        else $error("train started in standby");
    property p_abort; $fell(mode_active_o) |-> ##[1:2] !meas_busy_o; endproperty
    a_abort: assert property (p_abort)
        else $error("train not stopped by standby");
    property p_done; meas_done_o |-> $past(meas_busy_o) && !meas_busy_o ##1 !meas_done_o; endproperty
    a_done: assert property (p_done)
        else $error("done pulse out of place");
    property p_busy_max; busy_cnt_q <= BUSY_MAX; endproperty
    a_busy_max: assert property (p_busy_max)
        else $error("train longer than fifteen slowest periods");
    property p_cur; meas_busy_o && $past(meas_busy_o) |-> $stable(led_current_code_o)
        && led_current_code_o inside {3'h0, 3'h1, 3'h2, 3'h3, 3'h5}; endproperty
    a_cur: assert property (p_cur)
        else $error("current code changed or undefined in a train");
    property p_gain; detector_gain_o != 2'h3; endproperty
    a_gain: assert property (p_gain)
        else $error("undefined gain code");
    property p_sat; sat_flag_o |-> $past(adc_saturated_i); endproperty
    a_sat: assert property (p_sat)
        else $error("saturation flag without saturation");
endmodule : plpc_top_monitor

bind plpc_top plpc_top_monitor #(.CLK_HZ(CLK_HZ)) u_plpc_top_monitor (
    .ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .scl_i(scl_i), .sda_i(sda_i),
    .sda_o(sda_o), .sda_oe_o(sda_oe_o), .meas_req_i(meas_req_i),
    .adc_saturated_i(adc_saturated_i), .sat_flag_o(sat_flag_o), .led_drive_o(led_drive_o),
    .led_current_code_o(led_current_code_o), .detector_gain_o(detector_gain_o),
    .mode_active_o(mode_active_o), .meas_busy_o(meas_busy_o), .meas_done_o(meas_done_o)
);
`default_nettype wire

/* File: verification/plpc_host.sv */
`timescale 1ns/1ps
`default_nettype none
module plpc_host
    import plpc_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic sda_line_i,
    output logic scl_o,
    output logic sda_pull_o,
    output logic rd_valid_o,
    output logic [7:0] rd_data_o,
    output logic [7:0] nack_count_o
);
    localparam int QTR = 8;
    initial begin
        scl_o = 1'b1;
        sda_pull_o = 1'b0;
        rd_valid_o = 1'b0;
        rd_data_o = 8'h00;
        nack_count_o = 8'h00;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk_i);
        #1;
    endtask : tick
    // ====
    // Bus conditions and bits
    task automatic start_cond;
        sda_pull_o = 1'b0;
        tick(QTR);
        scl_o = 1'b1;
        tick(QTR);
        sda_pull_o = 1'b1;
        tick(QTR);
        scl_o = 1'b0;
        tick(QTR);
    endtask : start_cond
    task automatic stop_cond;
        sda_pull_o = 1'b1;
        tick(QTR);
        scl_o = 1'b1;
        tick(QTR);
        sda_pull_o = 1'b0;
        tick(2 * QTR);
    endtask : stop_cond
    task automatic bit_io(input logic b, output logic r);
        sda_pull_o = !b;
        tick(QTR);
        scl_o = 1'b1;
        tick(QTR);
        r = sda_line_i;
        tick(QTR);
        scl_o = 1'b0;
        tick(QTR);
    endtask : bit_io
    task automatic byte_io(input logic [7:0] d, output logic [7:0] q);
        for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
    endtask : byte_io
    task automatic send(input logic [7:0] d);
        logic [7:0] q;
        logic a;
        byte_io(d, q);
        bit_io(1'b1, a);
        if (a) nack_count_o++;
    endtask : send
    // ====
    // Register access
    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        start_cond();
        send({PLPC_I2C_ADDR, 1'b0});
        send(a);
        send(d);
        stop_cond();
    endtask : write_reg
    task automatic read_reg(input logic [7:0] a);
        logic [7:0] q;
        logic n;
        start_cond();
        send({PLPC_I2C_ADDR, 1'b0});
        send(a);
        start_cond();
        send({PLPC_I2C_ADDR, 1'b1});
        byte_io(8'hff, q);
        bit_io(1'b1, n);
        stop_cond();
        rd_data_o = q;
        rd_valid_o = 1'b1;
        tick(1);
        rd_valid_o = 1'b0;
    endtask : read_reg
endmodule : plpc_host
`default_nettype wire

/* File: verification/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb
    import plpc_pkg::*;
;
    localparam logic [2:0] CURS [8] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h5, 3'h0, 3'h1, 3'h5};
    logic clk, resetn, meas_req, adc_sat, probe, scl, pull, line, sda_o, sda_oe;
    logic sat_flag, led, mode, busy, done, rd_valid;
    logic [2:0] cur;
    logic [1:0] gain, g;
    logic [3:0] n;
    logic [7:0] rd_data, nack_cnt;
    logic [31:0] lfsr;
    logic [15:0] busy_n, led_n;
    logic [7:0] rd_q[$];
    logic [6:0] st_q[$];
    logic [34:0] ms_q[$];
    int err_count, n_compared;
    assign line = !(pull || (sda_oe && !sda_o));
    plpc_top #(.CLK_HZ(PLPC_CLK_HZ)) u_plpc_top (.ref_clk_i(clk), .resetn_i(resetn),
        .scl_i(scl), .sda_i(line), .sda_o(sda_o), .sda_oe_o(sda_oe), .meas_req_i(meas_req),
        .adc_saturated_i(adc_sat), .sat_flag_o(sat_flag), .led_drive_o(led),
        .led_current_code_o(cur), .detector_gain_o(gain), .mode_active_o(mode),
        .meas_busy_o(busy), .meas_done_o(done));
    plpc_host u_plpc_host (.ref_clk_i(clk), .sda_line_i(line), .scl_o(scl), .sda_pull_o(pull),
        .rd_valid_o(rd_valid), .rd_data_o(rd_data), .nack_count_o(nack_cnt));
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr_next
    task automatic tick(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask : tick
    task automatic cmp(input logic [34:0] got, input logic [34:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : cmp
    task automatic results;
        if (err_count == 0 && n_compared > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : results
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        u_plpc_host.write_reg(a, d);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        rd_q.push_back(exp);
        u_plpc_host.read_reg(a);
    endtask : rd
    task automatic status(input logic [6:0] exp);
        st_q.push_back(exp);
        probe = 1'b1;
        tick(1);
        probe = 1'b0;
    endtask : status
    task automatic measure(input logic [2:0] f, input logic [1:0] d, input logic [2:0] c,
                           input logic [3:0] k, input bit go, input bit abort);
        int p;
        p = PLPC_CLK_HZ / (30000 + 10000 * int'(f));
        wr(PLPC_OFS_PULSE_SETTING, {f, d, c});
        wr(PLPC_OFS_PULSE_COUNT, {4'h0, k});
        if (go) ms_q.push_back({16'(int'(k) * p), 16'(int'(k) * (p * (int'(d) + 1) / 4)), c});
        meas_req = 1'b1;
        tick(1);
        meas_req = 1'b0;
        tick(5);
        meas_req = 1'b1;
        tick(1);
        meas_req = 1'b0;
        if (abort) wr(PLPC_OFS_CONTROL, 8'h00);
        for (int i = 0; i < 12000 && go; i++) begin
            @(posedge clk);
            if (done) break;
        end
        tick(20);
    endtask : measure
    // ====
    // Result watcher
    always @(posedge clk) begin
        if (rd_valid) cmp(35'(rd_data), rd_q.size() ? 35'(rd_q.pop_front()) : '1, "read");
        if (probe) cmp(35'({mode, gain, sat_flag, cur}), 35'(st_q.pop_front()), "status");
        if (done) begin
            cmp({busy_n, led_n, cur}, ms_q.size() ? ms_q.pop_front() : '1, "train");
            busy_n = 16'h0;
            led_n = 16'h0;
        end else if (!busy) begin
            busy_n = 16'h0;
            led_n = 16'h0;
        end else begin
            busy_n = busy_n + 16'h1;
            led_n = led_n + {15'h0, led};
        end
    end
    // ====
    // Clock, watchdog, sequence
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    initial begin
        repeat (95000) @(posedge clk);
        err_count++;
        results();
    end
    initial begin
        resetn = 1'b0;
        meas_req = 1'b0;
        adc_sat = 1'b0;
        probe = 1'b0;
        lfsr = 32'hdd21b4c7;
        repeat (6) @(posedge clk);
        #1;
        resetn = 1'b1;
        tick(3);
        status(7'h05);
        rd(PLPC_OFS_CONTROL, 8'h00);
        rd(PLPC_OFS_PULSE_SETTING, 8'h7f);
        rd(PLPC_OFS_PULSE_COUNT, 8'h01);
        rd(8'h90, 8'h00);
        for (int i = 0; i < 3; i++) begin
            lfsr = lfsr_next(lfsr);
            wr(PLPC_OFS_PULSE_SETTING, lfsr[7:0]);
            rd(PLPC_OFS_PULSE_SETTING, lfsr[7:0]);
            wr(PLPC_OFS_CONTROL, lfsr[15:8] & 8'h2f);
            rd(PLPC_OFS_CONTROL, lfsr[15:8] & 8'h2f);
        end
        for (int i = 0; i < 8; i++) begin
            lfsr = lfsr_next(lfsr);
            adc_sat = i[0] ? lfsr[0] : 1'b1;
            g = (i[1:0] == 2'b00) ? 2'h0 : (i[1:0] == 2'b10) ? 2'h1 : 2'h2;
            wr(PLPC_OFS_CONTROL, {2'b00, i[2], 1'b0, i[1:0], i[1:0]});
            status({i[1], g, i[2] & adc_sat, 3'h5});
        end
        wr(PLPC_OFS_CONTROL, 8'h00);
        measure(3'h3, 2'h3, 3'h5, 4'h1, 1'b0, 1'b0);
        wr(PLPC_OFS_CONTROL, 8'h02);
        for (int f = 0; f < 8; f++) begin
            n = (f == 7) ? 4'hf : 4'(2 * f + 1);
            measure(3'(f), 2'(f), CURS[f], n, 1'b1, 1'b0);
        end
        measure(3'h0, 2'h0, 3'h4, 4'h3, 1'b0, 1'b0);
        measure(3'h0, 2'h0, 3'h2, 4'h0, 1'b0, 1'b0);
        measure(3'h0, 2'h1, 3'h1, 4'hf, 1'b0, 1'b1);
        cmp(35'(rd_q.size() + st_q.size() + ms_q.size()), 35'h0, "pending");
        cmp(35'(nack_cnt), 35'h0, "acknowledge");
        results();
    end
endmodule : tb
`default_nettype wire
